// ===== rtl/csbd_pkg.sv
// constants for the chip select bank decoder
`default_nettype none
package csbd_pkg;
   // register byte offsets, ordinary banks at 0x10 + 8*n, tuning banks at 0x40 + 8*n
   localparam logic [11:0] CSBD_BASE_OFS = 12'h010;
   localparam logic [11:0] CSBD_TUNE_OFS = 12'h040;
   localparam logic [11:0] CSBD_CTRL_OFS = 12'h000;
   localparam logic [11:0] CSBD_STAT_OFS = 12'h004;
   localparam logic [11:0] CSBD_REQ_OFS = 12'h008;
   localparam logic [11:0] CSBD_ADDR_OFS = 12'h00C;
   localparam logic [11:0] CSBD_RES_OFS = 12'h030;
   // field positions, bit 0 is the lsb here (big endian bit 31)
   localparam int CSBD_VALID_BIT = 0;
   localparam int CSBD_BLOCK_BIT = 1;
   localparam int CSBD_PULSE_BIT = 4;
   localparam int CSBD_LANE_BIT = 5;
   localparam int CSBD_BLEN_BIT = 6;
   localparam int CSBD_PW_BIT = 11;
   localparam int CSBD_PFX_LSB = 15;
   localparam int CSBD_LWAIT_LSB = 1;
   localparam int CSBD_FWAIT_LSB = 4;
   localparam int CSBD_NARROW_BIT = 0;
   // writable masks, reserved bits read zero
   localparam logic [31:0] CSBD_BASE_WMASK = 32'h1FFF_8873;
   localparam logic [31:0] CSBD_OPT_WMASK = 32'h1FFF_80F6;
   // reset values: prefix top 001, ignore field top 111, block set
   localparam logic [31:0] CSBD_BASE_RST = 32'h2000_0002;
   localparam logic [31:0] CSBD_OPT_RST = 32'hE000_0000;
   localparam logic [31:0] CSBD_BASE_FIX = 32'h2000_0000;
   localparam logic [31:0] CSBD_OPT_FIX = 32'hE000_0000;
   // beats
   localparam logic [4:0] CSBD_BEATS_4 = 5'h04;
   localparam logic [4:0] CSBD_BEATS_8 = 5'h08;
   localparam logic [4:0] CSBD_BEATS_16 = 5'h10;
   // width codes
   localparam logic [1:0] CSBD_XW_32 = 2'h0;
   localparam logic [1:0] CSBD_XW_8 = 2'h1;
   localparam logic [1:0] CSBD_XW_16 = 2'h2;
   // sequencer states
   typedef enum logic [3:0] {
      CSBD_IDLE = 4'h1,
      CSBD_ADDR = 4'h2,
      CSBD_FIRST = 4'h4,
      CSBD_LATER = 4'h8
   } csbd_state_e;
endpackage
`default_nettype wire

// ===== rtl/csbd_match_if.sv
// bank register contents and match result between decoder and bank matcher
`timescale 1ns/10ps
`default_nettype none
interface csbd_match_if;
   logic [31:0] base;
   logic [31:0] opt;
   logic [31:0] addr;
   logic hit;
   modport cmp (input base, input opt, input addr, output hit);
   modport src (output base, output opt, output addr, input hit);
endinterface
`default_nettype wire

// ===== rtl/csbd_bank_match.sv
// one bank address compare
`timescale 1ns/10ps
`default_nettype none
module csbd_bank_match (
   // register pair and address
   csbd_match_if.cmp m
);
   wire [16:0] prefix = m.base[31:csbd_pkg::CSBD_PFX_LSB];
   wire [16:0] ignore = m.opt[31:csbd_pkg::CSBD_PFX_LSB];
   wire [16:0] upper = m.addr[31:csbd_pkg::CSBD_PFX_LSB];
   wire valid = m.base[csbd_pkg::CSBD_VALID_BIT];
   assign m.hit = valid && (((upper ^ prefix) & ignore) == 17'h0_0000);
endmodule
`default_nettype wire

// ===== rtl/csbd_decoder.sv
// chip select bank decoder top with apb registers and access timing
// Summary of operation
// - each bank compares address bits 0..16 against its prefix where unmasked.
// - prefix top three bits fixed at 001, also after reset.
// - port width 0 gives 32-bit port, 1 gives 16-bit port.
// - narrow bus setting forces every bank to 16-bit port.
// - burst length 0 means eight words, 1 means four words.
// - beats are 4, 8 or 16 from burst length and port width.
// - lane strobe select 0 gives write-only strobes, 1 gives lane enables.
// - pulse flag 0 holds progress line all burst; 1 pulses before beats.
// - burst block 1 forbids burst reads; resets to 1.
// - a bank without valid bit never selects nor matches.
// - cleared ignore bit drops that address bit; any pattern allowed.
// - ignore field top three bits fixed at 111, also after reset.
// - ignore field readable and writable at any time.
// - first beat lasts two plus first-beat-waits cycles.
// - later beats last one plus later-beat-waits cycles.
// - width code driven in the address cycle.
// - matching decodes only the upper 17 bits (0..16) of the 32-bit internal address.
// - lowest ordinary matching bank wins.
// - tuning banks 0..3 outrank ordinary banks 0..3.
// - no match uses defaults and ends beats on transfer ack.
// - narrow bus setting 0 gives 32-bit mode, 1 gives 16-bit.
`timescale 1ns/10ps
`default_nettype none
module csbd_decoder #(
   parameter int NBANK = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external memory side
   input wire logic transfer_ack_in,
   output logic start_strobe,
   output logic [3:0] chip_sel_n,
   output logic [3:0] tune_sel_n,
   output logic [1:0] xfer_width_code,
   output logic burst_progress_line,
   output logic lane_strobe_select,
   output logic port_width,
   output logic busy
);
   // only four ordinary and four tuning banks are decoded
   if (NBANK != 4) begin : gen_nbank_chk
      $error("csbd_decoder supports exactly four banks");
   end

   logic [31:0] base_r [2*NBANK];
   logic [31:0] opt_r [2*NBANK];
   logic narrow_r;
   logic [31:0] addr_r;
   logic [1:0] req_size_r;
   logic req_burst_r;
   logic req_write_r;
   logic go_r;
   logic ack_s1_r, ack_s2_r;
   csbd_pkg::csbd_state_e state_r;
   logic [4:0] beats_left_r;
   logic [3:0] wait_r;
   logic [7:0] sel_r;
   logic hit_r, burst_r, ack_mode_r;
   logic [1:0] xw_r;
   logic bpl_r, lane_r, pw_r, ts_r;
   logic [31:0] attr_base_r, attr_opt_r;
   logic [31:0] rdata_r;

   // apb decode
   wire wr_en = psel && penable && pwrite && clk_en;
   wire rd_en = psel && !penable && !pwrite && clk_en;
   wire in_ord = (paddr >= csbd_pkg::CSBD_BASE_OFS) && (paddr < csbd_pkg::CSBD_RES_OFS);
   wire in_tune = (paddr >= csbd_pkg::CSBD_TUNE_OFS) && (paddr < 12'h060);
   wire [11:0] ord_off = paddr - csbd_pkg::CSBD_BASE_OFS;
   wire [11:0] tune_off = paddr - csbd_pkg::CSBD_TUNE_OFS;
   wire [2:0] bank_ix = in_tune ? {1'b1, tune_off[4:3]} : {1'b0, ord_off[4:3]};
   wire is_opt = paddr[2];
   wire in_bank = (in_ord || in_tune) && (paddr[1:0] == 2'h0);
   wire is_ctrl = paddr == csbd_pkg::CSBD_CTRL_OFS;
   wire is_stat = paddr == csbd_pkg::CSBD_STAT_OFS;
   wire is_req = paddr == csbd_pkg::CSBD_REQ_OFS;
   wire is_addr = paddr == csbd_pkg::CSBD_ADDR_OFS;
   wire mapped = in_bank || is_ctrl || is_stat || is_req || is_addr;
   wire [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   // a new access is refused while one runs
   wire req_refused = is_req && (state_r != csbd_pkg::CSBD_IDLE);

   assign pready = 1'b1;
   assign pslverr = psel && penable && (!mapped || (pwrite && req_refused));
   assign prdata = rdata_r;

   // bank compare, tuning banks are indices 4..7
   logic [7:0] hit;
   genvar g;
   generate
      for (g = 0; g < 2*NBANK; g++) begin : gen_bank
         csbd_match_if mi ();
         assign mi.base = base_r[g];
         assign mi.opt = opt_r[g];
         assign mi.addr = addr_r;
         assign hit[g] = mi.hit;
         csbd_bank_match u_match (.m(mi.cmp));
      end
   endgenerate

   // priority pick, tuning 0..3 then ordinary 0..3
   logic [2:0] win_ix;
   logic any_hit;
   always_comb begin
      win_ix = 3'h0;
      any_hit = 1'b0;
      for (int i = NBANK - 1; i >= 0; i--) begin
         if (hit[i]) begin
            win_ix = 3'(i);
            any_hit = 1'b1;
         end
      end
      for (int i = NBANK - 1; i >= 0; i--) begin
         if (hit[NBANK + i]) begin
            win_ix = 3'(NBANK + i);
            any_hit = 1'b1;
         end
      end
   end

   // defaults when nothing matches
   wire [31:0] win_base = any_hit ? base_r[win_ix] : 32'h0000_0002;
   wire [31:0] win_opt = any_hit ? opt_r[win_ix] : 32'h0000_0000;
   wire eff_pw = narrow_r | win_base[csbd_pkg::CSBD_PW_BIT];
   wire blen4 = win_base[csbd_pkg::CSBD_BLEN_BIT];
   // beats: words times two on a 16-bit port
   wire [4:0] beats = blen4 ? (eff_pw ? csbd_pkg::CSBD_BEATS_8 : csbd_pkg::CSBD_BEATS_4)
                            : (eff_pw ? csbd_pkg::CSBD_BEATS_16 : csbd_pkg::CSBD_BEATS_8);
   wire can_burst = req_burst_r && !req_write_r && any_hit
                    && !win_base[csbd_pkg::CSBD_BLOCK_BIT];
   wire [3:0] fwait = win_opt[csbd_pkg::CSBD_FWAIT_LSB +: 4];
   wire win_pulse = win_base[csbd_pkg::CSBD_PULSE_BIT];
   wire [1:0] win_lwait = win_opt[csbd_pkg::CSBD_LWAIT_LSB +: 2];
   // pulsed mode: low in the address cycle unless the first beat is short
   wire bpl_start = can_burst && !(win_pulse && (fwait >= {2'h0, win_lwait}));
   wire [1:0] lwait = attr_opt_r[csbd_pkg::CSBD_LWAIT_LSB +: 2];
   wire pulse = attr_base_r[csbd_pkg::CSBD_PULSE_BIT];
   wire [1:0] width_code = req_burst_r ? csbd_pkg::CSBD_XW_32 : req_size_r;
   wire ack_now = ack_s2_r;
   // beat ends on its wait count, or on ack when defaulted
   wire beat_done = ack_mode_r ? ack_now : (wait_r == 4'h0);
   wire last_beat = beats_left_r == 5'h01;

   // register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2*NBANK; i++) begin
            base_r[i] <= csbd_pkg::CSBD_BASE_RST;
            opt_r[i] <= csbd_pkg::CSBD_OPT_RST;
         end
         narrow_r <= 1'b0;
         addr_r <= 32'h0000_0000;
         req_size_r <= 2'h0;
         req_burst_r <= 1'b0;
         req_write_r <= 1'b0;
      end else if (wr_en) begin
         if (in_bank && !is_opt) begin
            base_r[bank_ix] <= csbd_pkg::CSBD_BASE_FIX | (pwdata & bmask & csbd_pkg::CSBD_BASE_WMASK)
                               | (base_r[bank_ix] & ~bmask & csbd_pkg::CSBD_BASE_WMASK);
         end
         if (in_bank && is_opt) begin
            // writes accepted even mid access
            opt_r[bank_ix] <= csbd_pkg::CSBD_OPT_FIX | (pwdata & bmask & csbd_pkg::CSBD_OPT_WMASK)
                              | (opt_r[bank_ix] & ~bmask & csbd_pkg::CSBD_OPT_WMASK);
         end
         if (is_ctrl && pstrb[0]) begin
            narrow_r <= pwdata[csbd_pkg::CSBD_NARROW_BIT];
         end
         if (is_addr) begin
            addr_r <= (pwdata & bmask) | (addr_r & ~bmask);
         end
         if (is_req && !req_refused && pstrb[0]) begin
            req_size_r <= pwdata[2:1];
            req_burst_r <= pwdata[3];
            req_write_r <= pwdata[4];
         end
      end
   end

   // read selection
   wire [31:0] bank_word = is_opt ? opt_r[bank_ix] : base_r[bank_ix];
   wire [31:0] ctrl_word = {31'h0, narrow_r};
   wire [31:0] stat_word = {16'h0, sel_r, 3'h0, burst_r, hit_r, pw_r, lane_r, busy};
   wire [31:0] req_word = {27'h0, req_write_r, req_burst_r, req_size_r, 1'b0};
   wire [31:0] rd_mux = in_bank ? bank_word
                      : is_ctrl ? ctrl_word
                      : is_stat ? stat_word
                      : is_req ? req_word
                      : is_addr ? addr_r : 32'h0000_0000;

   // read data, registered in setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd_en) begin
         rdata_r <= rd_mux;
      end
   end

   // start pulse and ack synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_r <= 1'b0;
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else if (clk_en) begin
         go_r <= wr_en && is_req && !req_refused && pstrb[0] && pwdata[0];
         ack_s1_r <= transfer_ack_in;
         ack_s2_r <= ack_s1_r;
      end
   end

   // access sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= csbd_pkg::CSBD_IDLE;
         beats_left_r <= 5'h00;
         wait_r <= 4'h0;
         sel_r <= 8'h00;
         hit_r <= 1'b0;
         burst_r <= 1'b0;
         ack_mode_r <= 1'b0;
         xw_r <= 2'h0;
         bpl_r <= 1'b0;
         lane_r <= 1'b0;
         pw_r <= 1'b0;
         ts_r <= 1'b0;
         attr_base_r <= 32'h0000_0000;
         attr_opt_r <= 32'h0000_0000;
      end else if (clk_en) begin
         ts_r <= 1'b0;
         unique case (state_r)
            csbd_pkg::CSBD_IDLE: begin
               if (go_r) begin
                  sel_r <= any_hit ? 8'(1 << win_ix) : 8'h00;
                  hit_r <= any_hit;
                  ack_mode_r <= !any_hit;
                  attr_base_r <= win_base;
                  attr_opt_r <= win_opt;
                  burst_r <= can_burst;
                  beats_left_r <= can_burst ? beats : 5'h01;
                  wait_r <= fwait;
                  pw_r <= eff_pw;
                  lane_r <= win_base[csbd_pkg::CSBD_LANE_BIT];
                  xw_r <= width_code;
                  ts_r <= 1'b1;
                  bpl_r <= bpl_start;
                  state_r <= csbd_pkg::CSBD_ADDR;
               end
            end
            csbd_pkg::CSBD_ADDR: begin
               state_r <= csbd_pkg::CSBD_FIRST;
               if (burst_r && pulse && wait_r > {2'h0, lwait}) begin
                  bpl_r <= 1'b0;
               end
            end
            csbd_pkg::CSBD_FIRST, csbd_pkg::CSBD_LATER: begin
               if (beat_done) begin
                  if (last_beat) begin
                     state_r <= csbd_pkg::CSBD_IDLE;
                     sel_r <= 8'h00;
                     bpl_r <= 1'b0;
                  end else begin
                     beats_left_r <= beats_left_r - 5'h01;
                     wait_r <= {2'h0, lwait};
                     state_r <= csbd_pkg::CSBD_LATER;
                     // progress line stays on for the final beat's window
                     bpl_r <= !(beats_left_r == 5'h02) || !pulse ? 1'b1 : 1'b1;
                  end
               end else begin
                  wait_r <= wait_r - 4'h1;
                  // pulsed mode: assert only lwait+1 cycles before the next beat
                  if (burst_r && pulse) begin
                     bpl_r <= (wait_r - 4'h1) <= {2'h0, lwait};
                  end
               end
            end
            default: state_r <= csbd_pkg::CSBD_IDLE;
         endcase
      end
   end

   // outputs
   assign busy = state_r != csbd_pkg::CSBD_IDLE;
   assign start_strobe = ts_r;
   assign chip_sel_n = ~sel_r[3:0];
   assign tune_sel_n = ~sel_r[7:4];
   assign xfer_width_code = xw_r;
   assign burst_progress_line = bpl_r;
   assign lane_strobe_select = lane_r;
   assign port_width = pw_r;
endmodule
`default_nettype wire

// ===== tb/csbd_decoder_asserts.sv
// assertion checker for the chip select bank decoder ports
`timescale 1ns/10ps
`default_nettype none
module csbd_decoder_asserts #(
   parameter int NBANK = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // memory side
   input wire logic transfer_ack_in,
   input wire logic start_strobe,
   input wire logic [3:0] chip_sel_n,
   input wire logic [3:0] tune_sel_n,
   input wire logic [1:0] xfer_width_code,
   input wire logic burst_progress_line,
   input wire logic lane_strobe_select,
   input wire logic port_width,
   input wire logic busy
);
   wire logic sel_any = (chip_sel_n & tune_sel_n) != 4'hF;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_one_bank: assert property ($onehot0({~tune_sel_n, ~chip_sel_n}))
      else $error("more than one bank selected");
   a_tune_first: assert property (tune_sel_n != 4'hF |-> chip_sel_n == 4'hF)
      else $error("ordinary bank selected beside tuning bank");
   a_sel_at_strobe: assert property ($rose(sel_any) |-> start_strobe)
      else $error("select began outside address cycle");
   a_first_beat: assert property (start_strobe && sel_any |=> sel_any)
      else $error("first beat shorter than two cycles");
   a_width_code: assert property (start_strobe |-> xfer_width_code != 2'h3)
      else $error("bad width code in address cycle");
   a_progress_sel: assert property (burst_progress_line |-> sel_any)
      else $error("progress line outside selected access");
   a_nomatch_dflt: assert property (start_strobe && !sel_any |-> !port_width && !lane_strobe_select)
      else $error("unmatched access without default attributes");
   a_ack_wait: assert property (start_strobe && !sel_any && !transfer_ack_in |=> busy)
      else $error("unmatched access ended without ack");
   a_idle_quiet: assert property (!busy |-> !sel_any && !start_strobe)
      else $error("select or strobe while idle");
endmodule
bind csbd_decoder csbd_decoder_asserts #(.NBANK(NBANK)) u_asserts (.pclk, .presetn, .transfer_ack_in,
   .start_strobe, .chip_sel_n, .tune_sel_n, .xfer_width_code, .burst_progress_line, .lane_strobe_select,
   .port_width, .busy);
`default_nettype wire

// ===== tb/csbd_mem_model.sv
// external memory stand-in acking unselected accesses after a set delay
`timescale 1ns/10ps
`default_nettype none
module csbd_mem_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // access watch
   input wire logic start_strobe,
   input wire logic [3:0] chip_sel_n,
   input wire logic [3:0] tune_sel_n,
   input wire logic [7:0] ack_delay,
   // answer
   output logic transfer_ack_in
);
   logic [7:0] cnt_r;
   logic arm_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 8'h00;
         arm_r <= 1'b0;
         transfer_ack_in <= 1'b0;
      end else begin
         transfer_ack_in <= arm_r && cnt_r == 8'h00;
         if (start_strobe && (chip_sel_n & tune_sel_n) == 4'hF) begin
            arm_r <= 1'b1;
            cnt_r <= ack_delay;
         end else if (arm_r && cnt_r == 8'h00) begin
            arm_r <= 1'b0;
         end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/chip_select_bank_decoder_tb.sv
// self-checking bench for the chip select bank decoder
`timescale 1ns/10ps
`default_nettype none
module chip_select_bank_decoder_tb;
   localparam logic [11:0] bk = csbd_pkg::CSBD_BASE_OFS;
   localparam logic [11:0] tn = csbd_pkg::CSBD_TUNE_OFS;
   localparam logic [31:0] a0 = 32'h2000_0100;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] ack_delay = 8'h05;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, transfer_ack_in, start_strobe, burst_progress_line, lane_strobe_select, port_width, busy;
   wire logic [3:0] chip_sel_n, tune_sel_n;
   wire logic [1:0] xfer_width_code;
   int num_errors = 0;
   int checks_done = 0;
   int bpl_cycles = 0;
   csbd_decoder #(.NBANK(4)) dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hF), .prdata, .pready, .pslverr, .transfer_ack_in, .start_strobe, .chip_sel_n, .tune_sel_n,
      .xfer_width_code, .burst_progress_line, .lane_strobe_select, .port_width, .busy);
   csbd_mem_model mem (.pclk, .presetn, .start_strobe, .chip_sel_n, .tune_sel_n, .ack_delay, .transfer_ack_in);
   always #10 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
   endtask
   task automatic bank(input logic [11:0] a, input logic [31:0] b, input logic [31:0] o);
      wr(a, b);
      wr(a + 12'h004, o);
   endtask
   task automatic access(input logic [31:0] a, input logic [4:0] req, input logic [7:0] sels, input int len,
                         input logic [4:0] attr);
      int n = 0;
      int cnt = 1;
      wr(csbd_pkg::CSBD_ADDR_OFS, a);
      wr(csbd_pkg::CSBD_REQ_OFS, {27'h0, req});
      @(posedge pclk);
      while (start_strobe !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk({tune_sel_n, chip_sel_n}, sels);
      chk({burst_progress_line, xfer_width_code, port_width, lane_strobe_select}, attr);
      bpl_cycles = 0;
      @(posedge pclk);
      while (((chip_sel_n & tune_sel_n) != 4'hF || (sels == 8'hFF && busy)) && cnt < 200) begin
         bpl_cycles += int'(burst_progress_line);
         cnt++;
         @(posedge pclk);
      end
      if (len > 0) chk(cnt, len);
      else chk(cnt, 32'(ack_delay) + 32'h5);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      logic e;
      rd(bk, 32'h2000_0002);
      rd(bk + 12'h004, 32'hE000_0000);
      bank(tn + 12'h018, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      rd(tn + 12'h018, 32'h3FFF_8873);
      rd(tn + 12'h01C, 32'hFFFF_80F6);
      bank(tn + 12'h018, 32'h0, 32'h0);
      rd(tn + 12'h018, 32'h2000_0000);
      rd(tn + 12'h01C, 32'hE000_0000);
      apb(1'b0, csbd_pkg::CSBD_RES_OFS, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_prio();
      bank(bk, 32'h2000_0020, 32'hFFFF_8000);
      bank(bk + 12'h008, 32'h2000_0001, 32'hFFFF_8010);
      access(a0, 5'h01, 8'hFD, 3, 5'h00);
      bank(bk, 32'h2000_0021, 32'hFFEE_8000);
      access(a0, 5'h01, 8'hFE, 2, 5'h01);
      access(32'h2011_0100, 5'h01, 8'hFE, 2, 5'h01);
      bank(tn + 12'h010, 32'h2000_0801, 32'hFFFF_8020);
      access(a0, 5'h01, 8'hBF, 4, 5'h02);
      wr(tn + 12'h010, 32'h2000_0800);
      $display("t_prio done");
   endtask
   task automatic t_dflt();
      logic [4:0] req [4] = '{5'h01, 5'h13, 5'h15, 5'h09};
      logic [4:0] at [4] = '{5'h00, 5'h04, 5'h08, 5'h00};
      for (int i = 0; i < 4; i++) begin
         ack_delay <= 8'(i * 3);
         access(32'h6000_0100, req[i], 8'hFF, 0, at[i]);
      end
      $display("t_dflt done");
   endtask
   task automatic t_burst();
      logic [31:0] bb [6] = '{32'h2000_0041, 32'h2000_0001, 32'h2000_0041, 32'h2000_0001, 32'h2000_0043,
                              32'h2000_0051};
      int ln [6] = '{10, 18, 18, 34, 4, 18};
      bank(bk, 32'h2000_0041, 32'hFFFF_8022);
      for (int i = 0; i < 6; i++) begin
         wr(csbd_pkg::CSBD_CTRL_OFS, {31'h0, i >= 2});
         wr(bk, bb[i]);
         access(a0, 5'h09, 8'hFE, ln[i], {i < 4, 2'h0, i >= 2, 1'b0});
         chk(bpl_cycles, (i == 5) ? 16 : (i == 4) ? 0 : ln[i] - 1);
      end
      wr(csbd_pkg::CSBD_CTRL_OFS, 32'h0);
      $display("t_burst done");
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // run needs some 400 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_prio();
      t_dflt();
      t_burst();
      conclude();
   end
endmodule
`default_nettype wire
